/* tb/frontend_clamp_power_ctrl_regs_tb.sv */
`timescale 1ns/100ps
module frontend_clamp_power_ctrl_regs_tb;
    import fe_ctrl_pkg::*;
    typedef struct {logic [11:0] addr; logic [31:0] data; logic [3:0] strb; logic [15:0] rexp;} row_t;
    logic              sys_clk = 1'h0;
    logic              nrst = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = '0;
    logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, die_b_power_mode;
    logic              amp_output_half_clamp, harmonic_filter_enable, volt_to_current_clamp_enable;
    logic              input_highpass_divide_three, die_b_full_powerdown, die_b_fast_powerdown;
    logic              die_b_input_amp_powerdown, die_b_atten_gain_powerdown, die_b_mode_apply;
    logic              die_b_low_noise_figure, pair_mapping;
    logic [7:0]        odd_channel_powerdown;
    logic [15:0]       sc = '0, pw = '0;
    logic              off = 1'h0;
    int                error_cnt = 0;
    int                comparisons = 0;
    // unmapped rows sit last so the model keeps the previous mapped state
    row_t rows [18] = '{
        '{SIG_CHAIN_ADDR, 32'h0000_e100, 4'hf, 16'he100}, '{DIE_B_POWER_ADDR, 32'h0000_f2ff, 4'hf, 16'hf2ff},
        '{OFFSET_CTRL_ADDR, 32'h0000_0001, 4'hf, 16'h0001}, '{DIE_B_POWER_ADDR, 32'h0000_8000, 4'hf, 16'h8000},
        '{DIE_B_POWER_ADDR, 32'h0000_4000, 4'hf, 16'h4000}, '{DIE_B_POWER_ADDR, 32'h0000_2000, 4'hf, 16'h2000},
        '{DIE_B_POWER_ADDR, 32'h0000_1000, 4'hf, 16'h1000}, '{DIE_B_POWER_ADDR, 32'h0000_0200, 4'hf, 16'h0200},
        '{DIE_B_POWER_ADDR, 32'h0000_0400, 4'hf, 16'h0400}, '{DIE_B_POWER_ADDR, 32'h0000_0800, 4'hf, 16'h0800},
        '{DIE_B_POWER_ADDR, 32'h0000_0c00, 4'hf, 16'h0c00}, '{DIE_B_POWER_ADDR, 32'h0000_00aa, 4'hf, 16'h00aa},
        '{DIE_B_POWER_ADDR, 32'h0000_0055, 4'hf, 16'h0055}, '{SIG_CHAIN_ADDR, 32'h0000_8000, 4'hf, 16'h8000},
        '{SIG_CHAIN_ADDR, 32'h0000_4000, 4'hf, 16'h4000}, '{SIG_CHAIN_ADDR, 32'h0000_2000, 4'hf, 16'h2000},
        '{SIG_CHAIN_ADDR, 32'h0000_0100, 4'hf, 16'h0100}, '{12'h338, 32'hffff_ffff, 4'hf, 16'h0000}};

    frontend_clamp_power_ctrl_regs uut (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .amp_output_half_clamp, .harmonic_filter_enable, .volt_to_current_clamp_enable,
        .input_highpass_divide_three, .die_b_full_powerdown, .die_b_fast_powerdown, .die_b_input_amp_powerdown,
        .die_b_atten_gain_powerdown, .die_b_mode_apply, .die_b_power_mode, .die_b_low_noise_figure,
        .odd_channel_powerdown, .pair_mapping);

    always #25 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ready is sampled on the falling edge, where nothing moves, so the handshake edge is never raced
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int   n;
        logic aw_hit, w_hit, b_hit;
        n = 0;
        b_hit = 1'h0;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        while (!b_hit && n < 50) begin
            @(negedge sys_clk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit  = s_axi_wvalid && s_axi_wready;
            b_hit  = s_axi_bvalid && s_axi_bready;
            r      = s_axi_bresp;
            @(posedge sys_clk);
            if (aw_hit) s_axi_awvalid <= 1'h0;
            if (w_hit) s_axi_wvalid <= 1'h0;
            if (b_hit) s_axi_bready <= 1'h0;
            n++;
        end
        if (!b_hit) chk(32'h0, 32'h1, "write response");
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ar_hit, r_hit;
        n = 0;
        r_hit = 1'h0;
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        while (!r_hit && n < 50) begin
            @(negedge sys_clk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit  = s_axi_rvalid && s_axi_rready;
            d      = s_axi_rdata;
            r      = s_axi_rresp;
            @(posedge sys_clk);
            if (ar_hit) s_axi_arvalid <= 1'h0;
            if (r_hit) s_axi_rready <= 1'h0;
            n++;
        end
        if (!r_hit) chk(32'h0, 32'h1, "read response");
    endtask

    task automatic check_outs();
        @(negedge sys_clk);
        chk(amp_output_half_clamp, sc[15], "half clamp");
        chk(harmonic_filter_enable, sc[14], "harmonic filter");
        chk(volt_to_current_clamp_enable, sc[13], "volt_to_current_clamp_enable");
        chk(input_highpass_divide_three, sc[8], "corner divide");
        chk(die_b_full_powerdown, off & pw[15], "full powerdown");
        chk(die_b_fast_powerdown, off & pw[14], "fast powerdown");
        chk(die_b_input_amp_powerdown, off & pw[13], "input amp powerdown");
        chk(die_b_atten_gain_powerdown, off & pw[12], "atten gain powerdown");
        chk(die_b_power_mode, off ? pw[11:10] : 2'h0, "power mode");
        chk(die_b_mode_apply, off, "mode apply");
        chk(die_b_low_noise_figure, off & pw[9], "low noise figure");
        chk(odd_channel_powerdown, off ? pw[7:0] : 8'h00, "odd channels");
        chk(pair_mapping, !off, "pair mapping");
    endtask

    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [15:0] e);
        logic [1:0]  resp;
        logic [1:0]  er;
        logic [31:0] rd;
        er = (a == SIG_CHAIN_ADDR || a == DIE_B_POWER_ADDR || a == OFFSET_CTRL_ADDR) ? RESP_OKAY : RESP_SLVERR;
        axi_write(a, d, s, resp);
        chk(resp, er, "bresp");
        axi_read(a, rd, resp);
        chk(rd, {16'h0000, e}, "readback");
        chk(resp, er, "rresp");
        if (a == SIG_CHAIN_ADDR) sc = e;
        else if (a == DIE_B_POWER_ADDR) pw = e;
        else if (a == OFFSET_CTRL_ADDR) off = e[0];
        check_outs();
    endtask

    task automatic rd_zero();
        logic [31:0] rd;
        logic [1:0]  resp;
        axi_read(SIG_CHAIN_ADDR, rd, resp);
        chk(rd, 32'h0, "signal chain reset");
        axi_read(DIE_B_POWER_ADDR, rd, resp);
        chk(rd, 32'h0, "power reset");
        axi_read(OFFSET_CTRL_ADDR, rd, resp);
        chk(rd, 32'h0, "offset reset");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'h1;
        check_outs();
        rd_zero();
        $display("reset values done");
        for (int i = 0; i < 18; i++) begin
            wr_chk(rows[i].addr, rows[i].data, rows[i].strb, rows[i].rexp);
            $display("row %0d done", i);
        end
        // lane strobes: only the enabled byte may change, upper lanes ignored
        wr_chk(DIE_B_POWER_ADDR, 32'h0000_a4c3, 4'h2, 16'ha455);
        wr_chk(DIE_B_POWER_ADDR, 32'h0000_00ff, 4'h1, 16'ha4ff);
        wr_chk(DIE_B_POWER_ADDR, 32'hffff_0000, 4'hc, 16'ha4ff);
        $display("byte strobes done");
        // clearing the offset must hide the die b settings while they stay stored
        wr_chk(OFFSET_CTRL_ADDR, 32'h0000_0000, 4'hf, 16'h0000);
        $display("offset clear done");
        @(posedge sys_clk);
        nrst <= 1'h0;
        sc = '0;
        pw = '0;
        off = 1'h0;
        check_outs();
        @(posedge sys_clk);
        nrst <= 1'h1;
        rd_zero();
        $display("mid-run reset done");
        wrap_up();
    end
endmodule

/* verilog/fe_ctrl_pkg.sv */
package fe_ctrl_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  SIG_CHAIN_IDX    = 8'hcd;
    localparam logic [7:0]  DIE_B_POWER_IDX  = 8'hd5;
    localparam logic [7:0]  OFFSET_CTRL_IDX  = 8'hd0;
    localparam logic [11:0] SIG_CHAIN_ADDR   = {2'h0, SIG_CHAIN_IDX, 2'h0};
    localparam logic [11:0] DIE_B_POWER_ADDR = {2'h0, DIE_B_POWER_IDX, 2'h0};
    localparam logic [11:0] OFFSET_CTRL_ADDR = {2'h0, OFFSET_CTRL_IDX, 2'h0};
    localparam int          ADDR_W           = 12;
    localparam logic [15:0] REG_RESET        = 16'h0000;
    // signal-chain fields
    localparam int          HALF_CLAMP_BIT   = 15;
    localparam int          HARM_FILT_BIT    = 14;
    localparam int          VOLT_TO_CURRENT_CLAMP_ENABLE_BIT    = 13;
    localparam int          HPF_DIV3_BIT     = 8;
    localparam logic [15:0] SIG_CHAIN_MASK   = 16'he100;
    // die b power fields
    localparam int          FULL_PD_BIT      = 15;
    localparam int          FAST_PD_BIT      = 14;
    localparam int          AMP_PD_BIT       = 13;
    localparam int          ATT_PD_BIT       = 12;
    localparam int          MODE_HI          = 11;
    localparam int          MODE_LO          = 10;
    localparam int          LOW_NF_BIT       = 9;
    localparam logic [15:0] POWER_MASK       = 16'hfeff;
    localparam logic [1:0]  MODE_LOW_NOISE   = 2'h0;
    localparam logic [1:0]  MODE_LOW_POWER   = 2'h1;
    localparam logic [1:0]  MODE_MED_POWER   = 2'h2;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

/* verilog/frontend_clamp_power_ctrl_regs.sv */
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - bit 15 drives amplifier output half clamp
// - bit 14 enables 5 MHz harmonic filter
// - bit 13 enables volt-to-current clamp
// - bit 8 divides highpass corner by three
// - full powerdown of die b when offset
// - fast partial powerdown of die b
// - input amplifier powerdown of die b only
// - attenuator and gain powerdown of die b
// - power mode select for die b
// - low noise figure enable on die b
// - odd channel amplifier powerdowns when offset
// - die b mode acts only with offset
// - offset bit selects pair or single mapping
module frontend_clamp_power_ctrl_regs
    import fe_ctrl_pkg::*;
(
    input  wire logic              sys_clk,                  // 20 MHz clock
    input  wire logic              nrst,                     // async reset, low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,             // write address
    input  wire logic              s_axi_awvalid,            // write address valid
    output logic                   s_axi_awready,            // write address ready
    input  wire logic [31:0]       s_axi_wdata,              // write data
    input  wire logic [3:0]        s_axi_wstrb,              // byte enables
    input  wire logic              s_axi_wvalid,             // write data valid
    output logic                   s_axi_wready,             // write data ready
    output logic [1:0]             s_axi_bresp,              // write response
    output logic                   s_axi_bvalid,             // response valid
    input  wire logic              s_axi_bready,             // response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,             // read address
    input  wire logic              s_axi_arvalid,            // read address valid
    output logic                   s_axi_arready,            // read address ready
    output logic [31:0]            s_axi_rdata,              // read data
    output logic [1:0]             s_axi_rresp,              // read response
    output logic                   s_axi_rvalid,             // read valid
    input  wire logic              s_axi_rready,             // read ready
    output logic                   amp_output_half_clamp,    // amp clamp to ~1.5 Vpp
    output logic                   harmonic_filter_enable,   // 5 MHz lowpass on
    output logic                   volt_to_current_clamp_enable, // volt_to_current_clamp_enable on
    output logic                   input_highpass_divide_three,  // corner / 3
    output logic                   die_b_full_powerdown,     // slow-wake powerdown
    output logic                   die_b_fast_powerdown,     // fast-wake powerdown
    output logic                   die_b_input_amp_powerdown, // input amp off
    output logic                   die_b_atten_gain_powerdown, // atten and gain off
    output logic                   die_b_mode_apply,         // die b mode takes effect
    output logic [1:0]             die_b_power_mode,         // selected mode
    output logic                   die_b_low_noise_figure,   // low NF on die b
    output logic [7:0]             odd_channel_powerdown,    // ch 15..1 amp chain off
    output logic                   pair_mapping              // offset clear: pairs programmed
);

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] sig_chain;
    logic [15:0] die_b_power;
    logic        addr_offset;
    logic [15:0] next_sig_chain;
    logic [15:0] next_die_b_power;
    logic        next_addr_offset;

    logic              aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              next_aw_held, next_w_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0]       next_w_data;
    logic [3:0]        next_w_strb;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_rvalid;
    logic [1:0]        next_rresp;
    logic [31:0]       next_rdata;
    logic              do_write;
    logic [15:0]       wmask;

    ////////////////////////////////////////////////////////////////////////////
    // write address and data are each held once, in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // decided here from the captured flags, before they are cleared below;
        // a continuous assign on the cleared flags would feed back into this block
        do_write = next_aw_held && next_w_held && !s_axi_bvalid;
        wmask = {{8{next_w_strb[1]}}, {8{next_w_strb[0]}}};
        next_sig_chain   = sig_chain;
        next_die_b_power = die_b_power;
        next_addr_offset = addr_offset;
        next_bvalid      = s_axi_bvalid && !s_axi_bready;
        next_bresp       = s_axi_bresp;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            // reserved bits are kept at zero, so a careless write cannot set them
            unique case (next_aw_addr)
                SIG_CHAIN_ADDR:
                    next_sig_chain = ((sig_chain & ~wmask) | (next_w_data[15:0] & wmask))
                                     & SIG_CHAIN_MASK;
                DIE_B_POWER_ADDR:
                    next_die_b_power = ((die_b_power & ~wmask) | (next_w_data[15:0] & wmask))
                                       & POWER_MASK;
                OFFSET_CTRL_ADDR:
                    if (next_w_strb[0]) begin
                        next_addr_offset = next_w_data[0];
                    end
                default:
                    next_bresp = RESP_SLVERR;
            endcase
        end
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp  = s_axi_rresp;
        next_rdata  = s_axi_rdata;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                SIG_CHAIN_ADDR:   next_rdata = {16'h0000, sig_chain};
                DIE_B_POWER_ADDR: next_rdata = {16'h0000, die_b_power};
                OFFSET_CTRL_ADDR: next_rdata = {31'h00000000, addr_offset};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sig_chain     <= REG_RESET;
            die_b_power   <= REG_RESET;
            addr_offset   <= 1'b0;
            aw_held       <= 1'b0;
            aw_addr       <= '0;
            w_held        <= 1'b0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
        end else begin
            sig_chain     <= next_sig_chain;
            die_b_power   <= next_die_b_power;
            addr_offset   <= next_addr_offset;
            aw_held       <= next_aw_held;
            aw_addr       <= next_aw_addr;
            w_held        <= next_w_held;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog controls, registered so they never glitch into the front end
    logic [15:0] ctrl_q;
    logic [7:0]  chan_q;
    logic [15:0] next_ctrl;
    logic [7:0]  next_chan;

    always_comb begin
        next_ctrl     = 16'h0000;
        next_ctrl[0]  = sig_chain[HALF_CLAMP_BIT];
        next_ctrl[1]  = sig_chain[HARM_FILT_BIT];
        next_ctrl[2]  = sig_chain[VOLT_TO_CURRENT_CLAMP_ENABLE_BIT];
        next_ctrl[3]  = sig_chain[HPF_DIV3_BIT];
        next_ctrl[4]  = addr_offset & die_b_power[FULL_PD_BIT];
        next_ctrl[5]  = addr_offset & die_b_power[FAST_PD_BIT];
        next_ctrl[6]  = addr_offset & die_b_power[AMP_PD_BIT];
        next_ctrl[7]  = addr_offset & die_b_power[ATT_PD_BIT];
        next_ctrl[8]  = addr_offset;
        next_ctrl[10:9] = addr_offset ? die_b_power[MODE_HI:MODE_LO] : MODE_LOW_NOISE;
        // low NF only meaningful in low-noise mode; software keeps that order
        next_ctrl[11] = addr_offset & die_b_power[LOW_NF_BIT];
        next_ctrl[12] = !addr_offset;
        next_chan     = addr_offset ? die_b_power[7:0] : 8'h00;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= 16'h1000;
            chan_q <= 8'h00;
        end else begin
            ctrl_q <= next_ctrl;
            chan_q <= next_chan;
        end
    end

    assign amp_output_half_clamp        = ctrl_q[0];
    assign harmonic_filter_enable       = ctrl_q[1];
    assign volt_to_current_clamp_enable = ctrl_q[2];
    assign input_highpass_divide_three  = ctrl_q[3];
    assign die_b_full_powerdown         = ctrl_q[4];
    assign die_b_fast_powerdown         = ctrl_q[5];
    assign die_b_input_amp_powerdown    = ctrl_q[6];
    assign die_b_atten_gain_powerdown   = ctrl_q[7];
    assign die_b_mode_apply             = ctrl_q[8];
    assign die_b_power_mode             = ctrl_q[10:9];
    assign die_b_low_noise_figure       = ctrl_q[11];
    assign pair_mapping                 = ctrl_q[12];
    assign odd_channel_powerdown        = chan_q;

    ////////////////////////////////////////////////////////////////////////////
    AST_HALF_CLAMP: assert property (@(posedge sys_clk) disable iff (!nrst)
        amp_output_half_clamp == $past(sig_chain[HALF_CLAMP_BIT]))
        else $error("half clamp does not follow register");
    AST_HARM_FILT: assert property (@(posedge sys_clk) disable iff (!nrst)
        harmonic_filter_enable == $past(sig_chain[HARM_FILT_BIT]))
        else $error("harmonic filter does not follow register");
    AST_V2I: assert property (@(posedge sys_clk) disable iff (!nrst)
        volt_to_current_clamp_enable == $past(sig_chain[VOLT_TO_CURRENT_CLAMP_ENABLE_BIT]))
        else $error("volt_to_current_clamp_enable does not follow register");
    AST_HPF_DIV3: assert property (@(posedge sys_clk) disable iff (!nrst)
        input_highpass_divide_three == $past(sig_chain[HPF_DIV3_BIT]))
        else $error("highpass divide not applied");
    AST_FULL_PD: assert property (@(posedge sys_clk) disable iff (!nrst)
        die_b_full_powerdown |-> $past(addr_offset) && $past(die_b_power[FULL_PD_BIT]))
        else $error("full powerdown without cause");
    AST_FAST_PD: assert property (@(posedge sys_clk) disable iff (!nrst)
        die_b_fast_powerdown == ($past(addr_offset) && $past(die_b_power[FAST_PD_BIT])))
        else $error("fast powerdown wrong");
    AST_AMP_PD: assert property (@(posedge sys_clk) disable iff (!nrst)
        die_b_input_amp_powerdown == ($past(addr_offset) && $past(die_b_power[AMP_PD_BIT])))
        else $error("input amp powerdown wrong");
    AST_ATT_PD: assert property (@(posedge sys_clk) disable iff (!nrst)
        die_b_atten_gain_powerdown == ($past(addr_offset) && $past(die_b_power[ATT_PD_BIT])))
        else $error("atten powerdown wrong");
    AST_MODE: assert property (@(posedge sys_clk) disable iff (!nrst)
        addr_offset |=> die_b_power_mode == $past(die_b_power[MODE_HI:MODE_LO]))
        else $error("power mode wrong");
    AST_LOW_NF: assert property (@(posedge sys_clk) disable iff (!nrst)
        die_b_low_noise_figure |-> $past(die_b_power[LOW_NF_BIT]))
        else $error("low noise figure without bit");
    AST_CHAN: assert property (@(posedge sys_clk) disable iff (!nrst)
        odd_channel_powerdown == ($past(addr_offset) ? $past(die_b_power[7:0]) : 8'h00))
        else $error("channel powerdown wrong");
    AST_MODE_GATE: assert property (@(posedge sys_clk) disable iff (!nrst)
        die_b_mode_apply == $past(addr_offset) && (die_b_mode_apply || die_b_power_mode == MODE_LOW_NOISE))
        else $error("mode applied without offset");
    AST_MAPPING: assert property (@(posedge sys_clk) disable iff (!nrst)
        pair_mapping == !$past(addr_offset))
        else $error("mapping flags disagree");
    AST_RESERVED: assert property (@(posedge sys_clk) disable iff (!nrst)
        (sig_chain & ~SIG_CHAIN_MASK) == 16'h0000 && die_b_power[8] == 1'b0)
        else $error("reserved bit set");
    AST_BRESP: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    // bus contract checks; a new transfer cannot start while its answer is pending
    AST_B_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
        else $error("write response not retired");
    AST_R_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
        else $error("read response not retired");
    AST_B_AFTER_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> s_axi_bvalid)
        else $error("write response missing");
    AST_R_AFTER_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read response missing");
    AST_RDATA_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped");
    AST_READ_SIG: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == SIG_CHAIN_ADDR)
        |=> s_axi_rdata == {16'h0000, $past(sig_chain)})
        else $error("signal chain readback wrong");
    AST_READ_POWER: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == DIE_B_POWER_ADDR)
        |=> s_axi_rdata == {16'h0000, $past(die_b_power)})
        else $error("power readback wrong");
    AST_NO_OFFSET: assert property (@(posedge sys_clk) disable iff (!nrst)
        !$past(addr_offset) |-> !die_b_full_powerdown && !die_b_fast_powerdown && !die_b_low_noise_figure
            && odd_channel_powerdown == 8'h00)
        else $error("die b control active without offset");

endmodule
